// ---- core/mrs_region_virt_ctrl.sv ----
// Region selector and virtualization control registers with trap checks
//
// Notes on behaviour
// - The selector holds the first-stage region number used by the indirect base/limit regs.
// - The region index lives in bits 7:0 and is zero-extended above the implemented width.
// - The implemented index width is ceil(log2(number of regions)), and one bit when there is a single region.
// - Regions are numbered 0 to X-1 in steps of one.
// - The selector has no defined reset value and nothing relies on one.
// - The selector is accessed by coprocessor 15 with opc1 0, opc2 1, CRn 6, CRm 2.
// - The selector is RW at levels one and two, not at user level, and not at level one with the general trap set.
// - Level-one selector writes trap on the write trap, reads on the read trap, and all on trap bit 6.
// - The control register holds an eight-bit machine identifier in bits 23:16, reset to zero.
// - Bit 2 makes level one/user multi-word base-restore accesses to stage-two Normal memory interruptible.
// - Bit 2 only takes effect while the hypervisor fast-interrupt configuration is set.
// - Bit 1 faults level one/user multi-word accesses crossing 64-bit boundaries in stage-two Device memory.
// - The control register is accessed with opc1 4, opc2 0, CRn 2, CRm 0, at level two only.
// - With level two present, level-one accesses to the control register trap when trap bit 2 is set.
// - The indirect limit register acts on whichever region the selector names.
`timescale 1ns/1ps
module mrs_region_virt_ctrl
    import mrs_pkg::*;
#(
    parameter int NUM_REGIONS = 16,
    parameter bit EL2_PRESENT = 1'b1,
    parameter int IDX_W = (NUM_REGIONS > 1) ? $clog2(NUM_REGIONS) : 1
) (
    // Clock, reset, enable
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    input wire logic clk_en_in,
    // Coprocessor access from the core
    input wire logic cp_valid_in,
    input wire logic cp_write_in,
    input wire logic [3:0] cp_coproc_in,
    input wire logic [2:0] cp_opc1_in,
    input wire logic [2:0] cp_opc2_in,
    input wire logic [3:0] cp_crn_in,
    input wire logic [3:0] cp_crm_in,
    input wire logic [1:0] cp_el_in,
    input wire logic [31:0] cp_wdata_in,
    output logic [31:0] cp_rdata_out,
    output logic cp_done_out,
    output logic cp_hyp_trap_out,
    output logic cp_undef_out,
    // Hypervisor controls
    input wire logic general_exception_trap_in,
    input wire logic vm_write_trap_in,
    input wire logic vm_read_trap_in,
    input wire logic hyp_trap_bit6_in,
    input wire logic hyp_trap_bit2_in,
    input wire logic fast_interrupt_config_in,
    // Access classification from the memory pipeline
    input wire logic mem_multiword_in,
    input wire logic mem_base_restore_in,
    input wire logic mem_low_el_in,
    input wire logic mem_s2_normal_in,
    input wire logic mem_s2_device_in,
    input wire logic [31:0] mem_first_addr_in,
    input wire logic [31:0] mem_last_addr_in,
    output logic mem_interruptible_out,
    output logic mem_s2_perm_fault_out,
    // Selected region and identifier to the protection unit
    output logic [IDX_W-1:0] region_index_out,
    output logic [7:0] vm_identifier_out
);

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    function automatic logic enc_match(input logic [2:0] o1, input logic [2:0] o2,
                                       input logic [3:0] n, input logic [3:0] m);
        enc_match = (cp_coproc_in == MRS_COPROC) && (cp_opc1_in == o1) &&
                    (cp_opc2_in == o2) && (cp_crn_in == n) && (cp_crm_in == m);
    endfunction

    wire logic hit_sel = cp_valid_in && enc_match(MRS_SEL_OPC1, MRS_SEL_OPC2,
                                                  MRS_SEL_CRN, MRS_SEL_CRM);
    wire logic hit_vc = cp_valid_in && enc_match(MRS_VC_OPC1, MRS_VC_OPC2,
                                                 MRS_VC_CRN, MRS_VC_CRM);
    wire logic at_el0 = (cp_el_in == MRS_EL0);
    wire logic at_el1 = (cp_el_in == MRS_EL1);
    wire logic at_el2 = (cp_el_in == MRS_EL2);

    // ----------------------------------------
    // Permission and trap
    // ----------------------------------------
    // Level one under the general trap is not a legal state; treated as undefined
    wire logic sel_el1_ok = at_el1 && !general_exception_trap_in;
    wire logic sel_trap = hit_sel && sel_el1_ok && (hyp_trap_bit6_in ||
                          (cp_write_in ? vm_write_trap_in : vm_read_trap_in));
    wire logic vc_trap = hit_vc && at_el1 && !general_exception_trap_in &&
                         EL2_PRESENT && hyp_trap_bit2_in;
    wire logic any_trap = sel_trap || vc_trap;
    wire logic sel_ok = hit_sel && (at_el2 || sel_el1_ok) && !sel_trap;
    wire logic vc_ok = hit_vc && at_el2;
    wire logic bad = cp_valid_in && !any_trap && !sel_ok && !vc_ok;
    wire logic step = clk_en_in;

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [IDX_W-1:0] region_index;
    logic [7:0] vm_identifier;
    logic stage2_normal_irq_enable;
    logic stage2_device_multiword_disable;

    // No reset on the selector: its start value is left undefined
    always_ff @(posedge sys_clk_in) begin
        if (step && sel_ok && cp_write_in) begin
            region_index <= cp_wdata_in[IDX_W-1:0];
        end
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            vm_identifier <= MRS_VM_ID_RST;
        end else if (step && vc_ok && cp_write_in) begin
            vm_identifier <= cp_wdata_in[MRS_VM_ID_MSB:MRS_VM_ID_LSB];
        end
    end

    // Feature bits have undefined reset values
    always_ff @(posedge sys_clk_in) begin
        if (step && vc_ok && cp_write_in) begin
            stage2_normal_irq_enable <= cp_wdata_in[MRS_NIE_BIT];
            stage2_device_multiword_disable <= cp_wdata_in[MRS_DMAD_BIT];
        end
    end

    // ----------------------------------------
    // Read data and response
    // ----------------------------------------
    logic [31:0] next_rdata;
    always_comb begin
        next_rdata = MRS_ZERO;
        if (sel_ok) begin
            next_rdata[IDX_W-1:0] = region_index;
        end else if (vc_ok) begin
            next_rdata[MRS_VM_ID_MSB:MRS_VM_ID_LSB] = vm_identifier;
            next_rdata[MRS_NIE_BIT] = stage2_normal_irq_enable;
            next_rdata[MRS_DMAD_BIT] = stage2_device_multiword_disable;
        end
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cp_rdata_out <= MRS_ZERO;
            cp_done_out <= 1'b0;
            cp_hyp_trap_out <= 1'b0;
            cp_undef_out <= 1'b0;
        end else if (step) begin
            if (cp_valid_in && !cp_write_in && (sel_ok || vc_ok)) begin
                cp_rdata_out <= next_rdata;
            end
            cp_done_out <= sel_ok || vc_ok;
            cp_hyp_trap_out <= any_trap;
            cp_undef_out <= bad;
        end
    end

    // ----------------------------------------
    // Second-stage access controls
    // ----------------------------------------
    wire logic crosses_dw = mem_first_addr_in[31:MRS_DW_BIT] != mem_last_addr_in[31:MRS_DW_BIT];
    assign mem_interruptible_out = fast_interrupt_config_in && stage2_normal_irq_enable &&
        mem_multiword_in && mem_base_restore_in && mem_low_el_in &&
        mem_s2_normal_in;
    assign mem_s2_perm_fault_out = stage2_device_multiword_disable && mem_multiword_in &&
        mem_low_el_in && mem_s2_device_in && crosses_dw;
    assign region_index_out = region_index;
    assign vm_identifier_out = vm_identifier;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    chk_trap_no_write: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        (clk_en_in && sel_trap) |=> $stable(region_index))
        else $error("Trapped selector access changed the register");
    chk_trap_flag: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        (clk_en_in && hit_sel && at_el1 && !general_exception_trap_in && hyp_trap_bit6_in)
        |=> cp_hyp_trap_out && !cp_done_out)
        else $error("Trap bit 6 did not trap selector access");
    chk_sel_write: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        (clk_en_in && sel_ok && cp_write_in)
        |=> region_index == $past(cp_wdata_in[IDX_W-1:0]))
        else $error("Selector write lost");
    chk_sel_el0: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        (clk_en_in && hit_sel && at_el0) |=> cp_undef_out && !cp_done_out)
        else $error("User level reached the selector");
    chk_vc_el1: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        (clk_en_in && hit_vc && at_el1) |=> !cp_done_out)
        else $error("Level one reached the control register");
    chk_vc_trap2: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        (clk_en_in && hit_vc && at_el1 && !general_exception_trap_in && hyp_trap_bit2_in)
        |=> cp_hyp_trap_out == EL2_PRESENT)
        else $error("Trap bit 2 ignored");
    chk_sel_rdata: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        (clk_en_in && sel_ok && !cp_write_in)
        |=> cp_rdata_out[31:IDX_W] == '0 && cp_done_out)
        else $error("Selector read not zero-extended");
    chk_nie_gate: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        !fast_interrupt_config_in |-> !mem_interruptible_out)
        else $error("Interruptible without fast-interrupt config");
    chk_dmad_cross: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        (mem_first_addr_in[31:MRS_DW_BIT] == mem_last_addr_in[31:MRS_DW_BIT])
        |-> !mem_s2_perm_fault_out)
        else $error("Fault on access within one doubleword");
    chk_vm_id_reset: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        $rose(nrst_in) |-> vm_identifier == MRS_VM_ID_RST)
        else $error("Identifier not zero after reset");
    chk_vc_write: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        (clk_en_in && vc_ok && cp_write_in)
        |=> vm_identifier == $past(cp_wdata_in[MRS_VM_ID_MSB:MRS_VM_ID_LSB]))
        else $error("Identifier write lost");
    chk_vc_trap_hold: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        (clk_en_in && vc_trap) |=> $stable(vm_identifier) && cp_hyp_trap_out)
        else $error("Trapped control access changed the register");
    chk_one_answer: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        (clk_en_in && cp_valid_in) |=> $onehot({cp_done_out, cp_hyp_trap_out, cp_undef_out}))
        else $error("Access did not get exactly one answer");
    // Frozen cycles must not advance any state, pulses included
    chk_freeze_hold: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        !clk_en_in |=> $stable(vm_identifier) && $stable(cp_done_out) &&
            $stable(cp_rdata_out))
        else $error("State moved while the clock enable was low");

endmodule

// ---- core/mrs_pkg.sv ----
// Constants and types for the region selector and virtualization control block
package mrs_pkg;
    // Coprocessor encodings
    localparam logic [2:0] MRS_SEL_OPC1 = 3'h0;
    localparam logic [2:0] MRS_SEL_OPC2 = 3'h1;
    localparam logic [3:0] MRS_SEL_CRN = 4'h6;
    localparam logic [3:0] MRS_SEL_CRM = 4'h2;
    localparam logic [2:0] MRS_VC_OPC1 = 3'h4;
    localparam logic [2:0] MRS_VC_OPC2 = 3'h0;
    localparam logic [3:0] MRS_VC_CRN = 4'h2;
    localparam logic [3:0] MRS_VC_CRM = 4'h0;
    localparam logic [3:0] MRS_COPROC = 4'hF;
    // Field layout
    localparam int MRS_REGION_MSB = 7;
    localparam int MRS_VM_ID_LSB = 16;
    localparam int MRS_VM_ID_MSB = 23;
    localparam int MRS_NIE_BIT = 2;
    localparam int MRS_DMAD_BIT = 1;
    localparam logic [7:0] MRS_VM_ID_RST = 8'h00;
    localparam logic [31:0] MRS_ZERO = 32'h0000_0000;
    // Aligned 64-bit boundary: byte address bit 3
    localparam int MRS_DW_BIT = 3;
    // Privilege levels
    typedef enum logic [1:0] {
        MRS_EL0 = 2'h0,
        MRS_EL1 = 2'h1,
        MRS_EL2 = 2'h2
    } mrs_el_t;
endpackage

// ---- verification/mrs_core_model.sv ----
// Core-side model that issues coprocessor register accesses
`timescale 1ns/1ps
module mrs_core_model
    import mrs_pkg::*;
(
    // Clock
    input wire logic sys_clk_in,
    // Access towards the block
    output logic cp_valid_out,
    output logic cp_write_out,
    output logic [2:0] cp_opc1_out,
    output logic [2:0] cp_opc2_out,
    output logic [3:0] cp_crn_out,
    output logic [3:0] cp_crm_out,
    output logic [1:0] cp_el_out,
    output logic [31:0] cp_wdata_out,
    // Answer from the block
    input wire logic [31:0] cp_rdata_in,
    input wire logic cp_done_in,
    input wire logic cp_hyp_trap_in,
    input wire logic cp_undef_in
);
    initial begin
        {cp_valid_out, cp_write_out, cp_opc1_out, cp_opc2_out} = '0;
        {cp_crn_out, cp_crm_out, cp_el_out, cp_wdata_out} = '0;
    end
    // Kind 0 selector, 1 control, 2 limit encoding (not decoded here), 3 selector, wrong coprocessor
    task automatic access(input int kind, input logic wr, input logic [1:0] el,
        input logic [31:0] wd, output logic [2:0] resp, output logic [31:0] rd);
        @(posedge sys_clk_in);
        cp_valid_out <= 1'b1;
        cp_write_out <= wr;
        cp_el_out <= el;
        cp_wdata_out <= wd;
        cp_opc1_out <= (kind == 1) ? MRS_VC_OPC1 : MRS_SEL_OPC1;
        cp_opc2_out <= (kind == 1) ? MRS_VC_OPC2 : MRS_SEL_OPC2;
        cp_crn_out <= (kind == 1) ? MRS_VC_CRN : MRS_SEL_CRN;
        cp_crm_out <= (kind == 1) ? MRS_VC_CRM : (kind == 2) ? 4'h3 : MRS_SEL_CRM;
        @(posedge sys_clk_in);
        cp_valid_out <= 1'b0;
        // Stale data must not look valid
        cp_wdata_out <= ~wd;
        #1;
        resp = {cp_done_in, cp_hyp_trap_in, cp_undef_in};
        rd = cp_rdata_in;
    endtask
endmodule

// ---- verification/mpu_region_select_and_virt_control_tb.sv ----
// Self-checking bench for the region selector and virtualization control block
`timescale 1ns/1ps
module mpu_region_select_and_virt_control_tb
    import mrs_pkg::*;
;
    logic sys_clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic [5:0] ctl = '0;
    logic [4:0] mf = '0;
    logic [31:0] fa = '0, la = '0, wd, rd, cp_wdata, cp_rdata, fa_n;
    logic cp_valid, cp_write, cp_done, cp_trap, cp_undef, m_int, m_flt, wr, xd;
    logic en = 1'b1;
    logic [3:0] cpx = MRS_COPROC;
    logic [2:0] cp_opc1, cp_opc2, resp, er;
    logic [3:0] cp_crn, cp_crm, region_idx, sel_m;
    logic [1:0] cp_el, el;
    logic [7:0] vm_id_out, vm_id_m = '0;
    logic nie_m, dmad_m;
    bit sel_ok, vc_ok, frz;
    int error_cnt = 0, num_checks = 0, seed = 32'h1a82a7a3, kind;
    always #20 sys_clk_in = ~sys_clk_in;
    mrs_core_model core_u (.sys_clk_in(sys_clk_in), .cp_valid_out(cp_valid),
        .cp_write_out(cp_write), .cp_opc1_out(cp_opc1), .cp_opc2_out(cp_opc2),
        .cp_crn_out(cp_crn), .cp_crm_out(cp_crm), .cp_el_out(cp_el),
        .cp_wdata_out(cp_wdata), .cp_rdata_in(cp_rdata), .cp_done_in(cp_done),
        .cp_hyp_trap_in(cp_trap), .cp_undef_in(cp_undef));
    mrs_region_virt_ctrl #(.NUM_REGIONS(12)) dut_u (.sys_clk_in(sys_clk_in),
        .nrst_in(nrst_in), .clk_en_in(en), .cp_valid_in(cp_valid),
        .cp_write_in(cp_write), .cp_coproc_in(cpx), .cp_opc1_in(cp_opc1),
        .cp_opc2_in(cp_opc2), .cp_crn_in(cp_crn), .cp_crm_in(cp_crm), .cp_el_in(cp_el),
        .cp_wdata_in(cp_wdata), .cp_rdata_out(cp_rdata), .cp_done_out(cp_done),
        .cp_hyp_trap_out(cp_trap), .cp_undef_out(cp_undef),
        .general_exception_trap_in(ctl[0]), .vm_write_trap_in(ctl[1]),
        .vm_read_trap_in(ctl[2]), .hyp_trap_bit6_in(ctl[3]), .hyp_trap_bit2_in(ctl[4]),
        .fast_interrupt_config_in(ctl[5]), .mem_multiword_in(mf[0]),
        .mem_base_restore_in(mf[1]), .mem_low_el_in(mf[2]), .mem_s2_normal_in(mf[3]),
        .mem_s2_device_in(mf[4]), .mem_first_addr_in(fa), .mem_last_addr_in(la),
        .mem_interruptible_out(m_int), .mem_s2_perm_fault_out(m_flt),
        .region_index_out(region_idx), .vm_identifier_out(vm_id_out));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_resp(input logic [2:0] e, input logic [2:0] g);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH resp expected %h seen %h", e, g);
        end
    endtask
    // Response code: 4 done, 2 trap, 1 refused
    function automatic logic [2:0] exp_resp(int k, logic w, logic [1:0] e);
        if (k >= 2 || e == MRS_EL0) return 3'h1;
        if (e == MRS_EL2) return 3'h4;
        if (ctl[0]) return 3'h1;
        if (k == 1) return ctl[4] ? 3'h2 : 3'h1;
        return (ctl[3] || (w && ctl[1]) || (!w && ctl[2])) ? 3'h2 : 3'h4;
    endfunction
    task automatic report_and_stop();
        $display("Checks %0d, errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #800000;
        error_cnt++;
        report_and_stop();
    end
    initial begin
        repeat (3) @(posedge sys_clk_in);
        nrst_in <= 1'b1;
        for (int i = 0; i < 400; i++) begin
            @(posedge sys_clk_in);
            // Clock enable dropped now and then: the access must be ignored
            frz = (i % 40 == 20);
            kind = (i < 2) ? i : int'($unsigned($random(seed)) % 4);
            fa_n = $random(seed);
            en <= !frz;
            cpx <= (kind == 3) ? 4'hE : MRS_COPROC;
            ctl <= 6'($random(seed));
            mf <= 5'($random(seed) | $random(seed));
            fa <= fa_n;
            la <= fa_n + 32'($random(seed) & 15);
            wr = (i < 2) ? 1'b1 : 1'($random(seed));
            el = (i < 2) ? 2'h2 : 2'($unsigned($random(seed)) % 3);
            wd = $random(seed);
            // Index kept below the region count, top index first
            if (kind == 0) wd[7:0] = (i == 0) ? 8'h0B : 8'(wd[7:0] % 8'h0C);
            core_u.access(kind, wr, el, wd, resp, rd);
            er = frz ? 3'h0 : exp_resp(kind, wr, el);
            chk_resp(er, resp);
            if (er == 3'h4 && !wr && kind == 0 && sel_ok)
                chk("sel_rd", {28'h0, sel_m}, rd);
            if (er == 3'h4 && !wr && kind == 1 && vc_ok)
                chk("vc_rd", {8'h0, vm_id_m, 13'h0, nie_m, dmad_m, 1'b0}, rd);
            if (er == 3'h4 && wr && kind == 0) {sel_ok, sel_m} = {1'b1, wd[3:0]};
            if (er == 3'h4 && wr && kind == 1)
                {vc_ok, vm_id_m, nie_m, dmad_m} = {1'b1, wd[23:16], wd[2], wd[1]};
            if (sel_ok) chk("index", 32'(sel_m), 32'(region_idx));
            chk("vm_id", 32'(vm_id_m), 32'(vm_id_out));
            if (vc_ok) begin
                xd = (fa[31:3] != la[31:3]);
                chk("intr", 32'(ctl[5] & nie_m & (&mf[3:0])), 32'(m_int));
                chk("fault", 32'(dmad_m & mf[0] & mf[2] & mf[4] & xd), 32'(m_flt));
            end
            // Mid-run reset: identifier clears, selector and feature bits are not reset
            if (i == 200) begin
                @(posedge sys_clk_in);
                nrst_in <= 1'b0;
                repeat (2) @(posedge sys_clk_in);
                nrst_in <= 1'b1;
                vm_id_m = '0;
            end
        end
        report_and_stop();
    end
endmodule
